// File: pkg/smi_defs.svh
// Numeric constants of the stepper indexer and chopper.
// Assumes a 20 MHz pclk; included by the package users.
`ifndef SMI_DEFS_SVH
`define SMI_DEFS_SVH
`define SMI_CLK_KHZ     20000
`define SMI_PWM_KHZ     50
`define SMI_PWM_CYC     (`SMI_CLK_KHZ / `SMI_PWM_KHZ)
`define SMI_PWM_W       9
`define SMI_MIX_PCT     75
`define SMI_MIX_CYC     (`SMI_PWM_CYC * `SMI_MIX_PCT / 100)
`define SMI_BLANK_NS    3750
`define SMI_BLANK_CYC   ((`SMI_BLANK_NS * `SMI_CLK_KHZ + 999999) / 1000000)
`define SMI_SENSE_GAIN  5
`define SMI_ADC_W       10
`define SMI_HOME_POS    7'h10
`define SMI_FULL_OFS    7'h10
`define SMI_DRV_OFF     4'h0
`define SMI_DRV_FWD     4'h9
`define SMI_DRV_REV     4'h6
`define SMI_DRV_SLOW    4'h5
`define SMI_REG_CTRL    8'h00
`define SMI_REG_STATUS  8'h04
`define SMI_REG_DAC     8'h08
`define SMI_CTRL_EN_BIT   0
`define SMI_CTRL_HOME_BIT 1
`endif

// File: pkg/smi_pkg.sv
// Shared types of the stepper indexer and chopper.
// Assumes smi_defs.svh for all numeric constants.
package smi_pkg;
   typedef enum logic [1:0] {SMI_DECAY_SLOW, SMI_DECAY_MIXED, SMI_DECAY_FAST} smi_decay_t;
   typedef enum logic [1:0] {SMI_CH_OFF, SMI_CH_DRIVE, SMI_CH_FAST, SMI_CH_SLOW} smi_chop_st_t;
   // Bridge switches; winding_out_a pair then winding_out_b pair
   typedef struct packed
   {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } smi_drive_t;
endpackage

// File: pkg/smi_chop_if.sv
// Hand-off between the indexer and one winding's chopper.
// Assumes both ends run on pclk; one instance per winding.
`timescale 1ns/10ps
`include "smi_defs.svh"
interface smi_chop_if;
   import smi_pkg::*;
   logic                  run;
   logic                  pwm_start;
   logic                  mix_late;
   logic [6:0]            pct;
   logic                  neg;
   logic                  dec;
   smi_decay_t            decay;
   logic [`SMI_ADC_W-1:0] sense;
   logic [`SMI_ADC_W-1:0] refv;
   smi_drive_t            drv;
   modport ctl (output run, pwm_start, mix_late, pct, neg, dec, decay, sense, refv, input drv);
   modport chop (input run, pwm_start, mix_late, pct, neg, dec, decay, sense, refv, output drv);
endinterface

// File: design/smi_chopper.sv
// One winding's current chopper: drive, blanking, decay.
// Assumes synchronised sense and reference and a PWM period strobe.
`timescale 1ns/10ps
`include "smi_defs.svh"
module smi_chopper
   import smi_pkg::*;
#(
   parameter int unsigned ZERO_LVL = 0
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Indexer side
   smi_chop_if.chop cif
);
   typedef struct packed
   {
      smi_chop_st_t st;
      logic [6:0]   blank;
      smi_drive_t   drv;
   } smi_chop_reg_t;

   smi_chop_reg_t r_r;
   smi_chop_reg_t r_nxt;
   logic          trip;
   logic          zero;

   // Percent scale moved to the sense side to avoid a divider
   assign trip = (20'(cif.sense) * 20'(`SMI_SENSE_GAIN * 100)) >= (20'(cif.refv) * 20'(cif.pct));
   assign zero = cif.sense <= `SMI_ADC_W'(ZERO_LVL);
   assign cif.drv = r_r.drv;

   always_comb
   begin
      r_nxt = r_r;
      if (!cif.run)
         r_nxt.st = SMI_CH_OFF;
      else if (cif.pwm_start)
      begin
         r_nxt.st    = SMI_CH_DRIVE;
         r_nxt.blank = 7'(`SMI_BLANK_CYC - 1);
      end
      else
      begin
         case (r_r.st)
            SMI_CH_DRIVE:
            begin
               if (r_r.blank != 7'h00)
                  r_nxt.blank = r_r.blank - 7'h01;
               else if (trip)
               begin
                  case (cif.decay)
                     SMI_DECAY_FAST: r_nxt.st = SMI_CH_FAST;
                     SMI_DECAY_SLOW: r_nxt.st = SMI_CH_SLOW;
                     default:        r_nxt.st = (cif.dec && !cif.mix_late) ? SMI_CH_FAST : SMI_CH_SLOW;
                  endcase
               end
            end
            SMI_CH_FAST:
            begin
               if (cif.decay == SMI_DECAY_MIXED && cif.mix_late)
                  r_nxt.st = SMI_CH_SLOW;
               else if (zero)
                  r_nxt.st = SMI_CH_OFF;
            end
            default: ;
         endcase
      end
      case (r_nxt.st)
         SMI_CH_DRIVE: r_nxt.drv = cif.neg ? `SMI_DRV_REV : `SMI_DRV_FWD;
         SMI_CH_FAST:  r_nxt.drv = cif.neg ? `SMI_DRV_FWD : `SMI_DRV_REV;
         SMI_CH_SLOW:  r_nxt.drv = `SMI_DRV_SLOW;
         default:      r_nxt.drv = `SMI_DRV_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   a_blank_hold:
   assert property (@(posedge pclk) disable iff (!presetn)
      (cif.run && !cif.pwm_start && r_r.st == SMI_CH_DRIVE && r_r.blank != 7'h00) |=> r_r.st == SMI_CH_DRIVE)
      else $error("sense acted on during blanking");
   a_mixed_slow:
   assert property (@(posedge pclk) disable iff (!presetn)
      (cif.run && !cif.pwm_start && r_r.st == SMI_CH_DRIVE && r_r.blank == 7'h00 && trip
       && cif.decay == SMI_DECAY_MIXED && !cif.dec) |=> r_r.drv == `SMI_DRV_SLOW)
      else $error("rising current did not use slow decay");
   a_mixed_switch:
   assert property (@(posedge pclk) disable iff (!presetn)
      (cif.run && !cif.pwm_start && r_r.st == SMI_CH_FAST && cif.decay == SMI_DECAY_MIXED && cif.mix_late)
      |=> r_r.st == SMI_CH_SLOW)
      else $error("mixed decay did not turn slow");
endmodule

// File: design/smi_indexer.sv
// Stepper microstep indexer with two chopped windings and an APB port.
// Assumes asynchronous pins from a motion controller, 20 MHz pclk.
`timescale 1ns/10ps
`include "smi_defs.svh"
module smi_indexer
   import smi_pkg::*;
#(
   parameter int unsigned ZERO_LVL = 0
)
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Step and control pins
   input  wire logic                  step_in,
   input  wire logic                  dir_in,
   input  wire logic                  output_enable_n,
   input  wire logic                  low_power_n,
   input  wire logic                  indexer_home_n,
   input  wire logic                  step_format_bit0,
   input  wire logic                  step_format_bit1,
   input  wire logic                  step_format_bit2,
   // Three-level decay pin, seen as level plus open detect
   input  wire logic                  decay_level_in,
   input  wire logic                  decay_open_in,
   // Digitised sense and reference, winding 1 and 2
   input  wire logic [`SMI_ADC_W-1:0] winding_sense_in_1,
   input  wire logic [`SMI_ADC_W-1:0] winding_sense_in_2,
   input  wire logic [`SMI_ADC_W-1:0] winding_reference_in_1,
   input  wire logic [`SMI_ADC_W-1:0] winding_reference_in_2,
   // Bridge switches, bit 0 winding 1, bit 1 winding 2
   output logic      [1:0]            winding_out_a_high,
   output logic      [1:0]            winding_out_a_low,
   output logic      [1:0]            winding_out_b_high,
   output logic      [1:0]            winding_out_b_low
);
   typedef struct packed
   {
      logic [1:0][`SMI_ADC_W-1:0] refv;
      logic [1:0][`SMI_ADC_W-1:0] sense;
      logic                       dec_open;
      logic                       dec_lvl;
      logic [2:0]                 fmt;
      logic                       home_n;
      logic                       lp_n;
      logic                       oe_n;
      logic                       dir;
      logic                       step;
   } smi_pins_t;

   typedef struct packed
   {
      smi_pins_t             s1;
      smi_pins_t             s2;
      logic                  step_prev;
      logic [6:0]            pos;
      logic [1:0]            dec;
      logic [`SMI_PWM_W-1:0] pwm;
      logic                  ctrl_en;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } smi_main_st_t;

   // Quarter-wave magnitudes in percent, 0 to 90 degrees
   localparam logic [6:0] SMI_TAB [0:32] = '{
      7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5E,
      7'h5C, 7'h5A, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4D, 7'h4A,
      7'h47, 7'h43, 7'h3F, 7'h3C, 7'h38, 7'h33, 7'h2F, 7'h2B,
      7'h26, 7'h22, 7'h1D, 7'h18, 7'h14, 7'h0F, 7'h0A, 7'h05,
      7'h00};

   smi_main_st_t    r_r;
   smi_main_st_t    r_nxt;
   smi_pins_t       pins_raw;
   smi_decay_t      decay_sel;
   logic            apb_setup;
   logic            apb_access;
   logic            wr_ctrl;
   logic            known;
   logic            home_req;
   logic            step_edge;
   logic            run;
   logic [6:0]      pos_next;
   logic [1:0][7:0] lvl_now;
   logic [1:0][7:0] lvl_next;
   logic [31:0]     rd_word;

   smi_chop_if cif [1:0] ();

   // Stride in 1/32 steps per format code
   function automatic logic [6:0] smi_step_size(input logic [2:0] fmt);
      case (fmt)
         3'h0:    return 7'h20;
         3'h1:    return 7'h10;
         3'h2:    return 7'h08;
         3'h3:    return 7'h04;
         3'h4:    return 7'h02;
         default: return 7'h01;
      endcase
   endfunction

   // Nearest valid state past pos on the grid of fmt
   function automatic logic [6:0] smi_next_pos(input logic [6:0] pos, input logic [2:0] fmt,
                                                input logic fwd);
      logic [6:0] size;
      logic [6:0] ofs;
      logic [6:0] t;
      logic [6:0] base;
      size = smi_step_size(fmt);
      ofs  = (fmt == 3'h0) ? `SMI_FULL_OFS : 7'h00;
      t    = pos - ofs;
      base = t & ~(size - 7'h01);
      // Seven-bit arithmetic wraps the electrical cycle
      if (fwd)
         return base + size + ofs;
      else if (base == t)
         return t - size + ofs;
      else
         return base + ofs;
   endfunction

   // Sign and percent of one winding; winding 2 lags a quarter
   function automatic logic [7:0] smi_level(input logic [6:0] pos, input logic wnd);
      logic [1:0] q;
      logic [5:0] k;
      logic [5:0] kc;
      q  = pos[6:5] - {1'b0, wnd};
      k  = {1'b0, pos[4:0]};
      kc = 6'h20 - k;
      case (q)
         2'h0:    return {1'b0, SMI_TAB[k]};
         2'h1:    return {1'b1, SMI_TAB[kc]};
         2'h2:    return {1'b1, SMI_TAB[k]};
         default: return {1'b0, SMI_TAB[kc]};
      endcase
   endfunction

   assign pins_raw = '{refv:     {winding_reference_in_2, winding_reference_in_1},
                       sense:    {winding_sense_in_2, winding_sense_in_1},
                       dec_open: decay_open_in,
                       dec_lvl:  decay_level_in,
                       fmt:      {step_format_bit2, step_format_bit1, step_format_bit0},
                       home_n:   indexer_home_n,
                       lp_n:     low_power_n,
                       oe_n:     output_enable_n,
                       dir:      dir_in,
                       step:     step_in};

   // Open pin wins over whatever level it floats to
   assign decay_sel = r_r.s2.dec_open ? SMI_DECAY_MIXED :
                      (r_r.s2.dec_lvl ? SMI_DECAY_FAST : SMI_DECAY_SLOW);

   assign apb_setup  = psel && !penable;
   assign apb_access = psel && penable && r_r.pready;
   assign known      = (paddr == `SMI_REG_CTRL) || (paddr == `SMI_REG_STATUS) ||
                       (paddr == `SMI_REG_DAC);
   assign wr_ctrl    = apb_access && pwrite && (paddr == `SMI_REG_CTRL);

   assign home_req  = !r_r.s2.home_n || (wr_ctrl && pwdata[`SMI_CTRL_HOME_BIT]);
   assign step_edge = r_r.s2.step && !r_r.step_prev;
   assign run       = !r_r.s2.oe_n && r_r.s2.lp_n && r_r.ctrl_en;
   assign pos_next  = smi_next_pos(r_r.pos, r_r.s2.fmt, r_r.s2.dir);

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         lvl_now[i]  = smi_level(r_r.pos, 1'(i));
         lvl_next[i] = smi_level(pos_next, 1'(i));
      end
   end

   always_comb
   begin
      case (paddr)
         `SMI_REG_CTRL:   rd_word = {31'h0000_0000, r_r.ctrl_en};
         `SMI_REG_STATUS: rd_word = {16'h0000, cif[1].drv != `SMI_DRV_OFF, cif[0].drv != `SMI_DRV_OFF,
                                     run, decay_sel, r_r.s2.fmt, r_r.s2.dir, r_r.pos};
         `SMI_REG_DAC:    rd_word = {16'h0000, lvl_now[1], lvl_now[0]};
         default:         rd_word = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      r_nxt           = r_r;
      r_nxt.s1        = pins_raw;
      r_nxt.s2        = r_r.s1;
      r_nxt.step_prev = r_r.s2.step;
      r_nxt.pwm       = (r_r.pwm == `SMI_PWM_W'(`SMI_PWM_CYC - 1)) ? '0 : r_r.pwm + `SMI_PWM_W'(1);
      // Answer is staged in setup so the access phase has no wait
      r_nxt.pready    = apb_setup;
      r_nxt.pslverr   = apb_setup && !known;
      r_nxt.prdata    = 32'h0000_0000;
      if (apb_setup && !pwrite)
         r_nxt.prdata = rd_word;
      if (wr_ctrl)
         r_nxt.ctrl_en = pwdata[`SMI_CTRL_EN_BIT];
      // Position survives disable and sleep; only home and step edges move it
      if (home_req)
      begin
         r_nxt.pos = `SMI_HOME_POS;
         r_nxt.dec = 2'b00;
      end
      else if (step_edge)
      begin
         r_nxt.pos = pos_next;
         for (int i = 0; i < 2; i++)
            r_nxt.dec[i] = lvl_next[i][6:0] < lvl_now[i][6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_r         <= '0;
         r_r.ctrl_en <= 1'b1;
         r_r.pos     <= `SMI_HOME_POS;
      end
      else
         r_r <= r_nxt;
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_wnd
      assign cif[g].run       = run;
      assign cif[g].pwm_start = r_r.pwm == '0;
      assign cif[g].mix_late  = r_r.pwm >= `SMI_PWM_W'(`SMI_MIX_CYC);
      assign cif[g].pct       = lvl_now[g][6:0];
      assign cif[g].neg       = lvl_now[g][7];
      assign cif[g].dec       = r_r.dec[g];
      assign cif[g].decay     = decay_sel;
      assign cif[g].sense     = r_r.s2.sense[g];
      assign cif[g].refv      = r_r.s2.refv[g];

      smi_chopper #(
         .ZERO_LVL (ZERO_LVL)
      ) u_chop (
         .pclk    (pclk),
         .presetn (presetn),
         .cif     (cif[g])
      );

      assign winding_out_a_high[g] = cif[g].drv.hs_a;
      assign winding_out_a_low[g]  = cif[g].drv.ls_a;
      assign winding_out_b_high[g] = cif[g].drv.hs_b;
      assign winding_out_b_low[g]  = cif[g].drv.ls_b;
   end

   assign prdata  = r_r.prdata;
   assign pready  = r_r.pready;
   assign pslverr = r_r.pslverr;

   a_home_pos:
   assert property (@(posedge pclk) disable iff (!presetn)
      !r_r.s2.home_n |=> r_r.pos == `SMI_HOME_POS)
      else $error("home pin did not restore 45 degrees");

   a_step_fwd:
   assert property (@(posedge pclk) disable iff (!presetn)
      (step_edge && !home_req && r_r.s2.dir && r_r.s2.fmt >= 3'h5)
      |=> r_r.pos == $past(r_r.pos) + 7'h01)
      else $error("forward microstep wrong");

   a_step_rev:
   assert property (@(posedge pclk) disable iff (!presetn)
      (step_edge && !home_req && !r_r.s2.dir && r_r.s2.fmt == 3'h1 && r_r.pos[3:0] == 4'h0)
      |=> r_r.pos == $past(r_r.pos) - 7'h10)
      else $error("reverse half step wrong");

   a_full_grid:
   assert property (@(posedge pclk) disable iff (!presetn)
      (step_edge && !home_req && r_r.s2.fmt == 3'h0) |=> r_r.pos[4:0] == 5'h10)
      else $error("full step left its valid states");

   a_home_dac:
   assert property (@(posedge pclk) disable iff (!presetn)
      r_r.pos == `SMI_HOME_POS |-> (cif[0].pct == 7'h47 && cif[1].pct == 7'h47 && !cif[0].neg && !cif[1].neg))
      else $error("home state DAC codes wrong");

   a_idle_off:
   assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> (winding_out_a_high | winding_out_a_low | winding_out_b_high | winding_out_b_low) == 2'b00)
      else $error("bridge driven while disabled");

   a_period_on:
   assert property (@(posedge pclk) disable iff (!presetn)
      (run && r_r.pwm == '0) |=> (winding_out_a_high | winding_out_b_high) == 2'b11 ##1
      (winding_out_a_high | winding_out_b_high) == 2'b11 || !$past(run))
      else $error("bridge not driven at period start");

   a_apb_wait:
   assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup |=> pready ##1 !pready)
      else $error("slave answer not one cycle");
endmodule

// File: bench/smi_step_ctrl.sv
// Motion controller model: step and direction pulses for the indexer.
// Assumes pclk at 20 MHz; the bench calls steps() just after a pclk edge.
`timescale 1ns/10ps
module smi_step_ctrl
(
   // Clock
   input  wire logic pclk,
   // Watched pins
   input  wire logic output_enable_n,
   input  wire logic low_power_n,
   // Driven pins
   output logic      step_in,
   output logic      dir_in
);
   // 2 us per level keeps both widths and the rate legal
   localparam int HALF_CYC = 40;
   localparam int ENBL_CYC = 4;
   localparam int WAKE_CYC = 20000;
   int en_age   = 0;
   int wake_age = 0;
   initial
   begin
      step_in = 1'b0;
      dir_in = 1'b1;
   end
   always @(posedge pclk)
   begin
      en_age <= output_enable_n ? 0 : en_age + 1;
      wake_age <= low_power_n ? wake_age + 1 : 0;
   end
   task automatic steps(input int n, input logic fwd);
      dir_in <= fwd;
      // Direction settles a full level before the edge
      repeat (HALF_CYC) @(posedge pclk);
      while (en_age < ENBL_CYC || wake_age < WAKE_CYC)
         @(posedge pclk);
      repeat (n)
      begin
         step_in <= 1'b1;
         repeat (HALF_CYC) @(posedge pclk);
         step_in <= 1'b0;
         repeat (HALF_CYC) @(posedge pclk);
      end
   endtask
endmodule

// File: bench/tb_stepper_microstep_indexer_chopper.sv
// Self-checking bench for the stepper indexer and chopper.
// Assumes smi_step_ctrl as motion controller and APB register access.
`timescale 1ns/10ps
`include "smi_defs.svh"
module tb_stepper_microstep_indexer_chopper;
   import smi_pkg::*;
   logic                  pclk     = 1'b0;
   logic                  presetn  = 1'b0;
   logic                  psel     = 1'b0;
   logic                  penable  = 1'b0;
   logic                  pwrite   = 1'b0;
   logic [7:0]            paddr    = 8'h00;
   logic [31:0]           pwdata   = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  step_in;
   logic                  dir_in;
   logic                  en_n     = 1'b0;
   logic                  wake_n   = 1'b1;
   logic                  home_n   = 1'b1;
   logic [2:0]            fmt      = 3'h5;
   logic                  dec_lvl  = 1'b0;
   logic                  dec_open = 1'b0;
   logic [`SMI_ADC_W-1:0] sense    = 10'h3FF;
   logic [`SMI_ADC_W-1:0] refv     = 10'h3E8;
   logic [1:0]            a_hi, a_lo, b_hi, b_lo;
   logic [31:0]           rd;
   logic                  err;
   int                    num_errors  = 0;
   int                    checks_done = 0;

   smi_indexer #(.ZERO_LVL(0)) dut_u
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .step_in, .dir_in, .output_enable_n(en_n), .low_power_n(wake_n), .indexer_home_n(home_n),
      .step_format_bit0(fmt[0]), .step_format_bit1(fmt[1]), .step_format_bit2(fmt[2]),
      .decay_level_in(dec_lvl), .decay_open_in(dec_open),
      .winding_sense_in_1(sense), .winding_sense_in_2(sense),
      .winding_reference_in_1(refv), .winding_reference_in_2(refv),
      .winding_out_a_high(a_hi), .winding_out_a_low(a_lo), .winding_out_b_high(b_hi), .winding_out_b_low(b_lo)
   );

   smi_step_ctrl ctl_u
   (
      .pclk, .output_enable_n(en_n), .low_power_n(wake_n), .step_in, .dir_in
   );

   always #25 pclk = ~pclk;

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_span(input string what, input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // Holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      chk_span("apb wait", n, 1, 1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic chk_pos(input logic [6:0] exp);
      apb(1'b0, `SMI_REG_STATUS, 32'h0);
      chk_word("position", {25'h0, exp}, {25'h0, rd[6:0]});
   endtask

   function automatic logic [3:0] pat1();
      return {a_hi[0], a_lo[0], b_hi[0], b_lo[0]};
   endfunction

   // Cycles until the match with p turns to eq, capped
   task automatic wait_pat(input logic [3:0] p, input bit eq, input int lim, output int n);
      n = 0;
      while (((pat1() === p) != eq) && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   // One whole PWM period of winding 1, or only up to the switch to late_p when it differs from off_p
   task automatic chop_period(input logic [3:0] on_p, input logic [3:0] off_p, input logic [3:0] late_p);
      int n;
      int m;
      bit plain;
      plain = (late_p === off_p);
      // Off phase first, so a drive cut short by a table change is skipped
      wait_pat(off_p, 1'b1, 900, n);
      wait_pat(on_p, 1'b1, 900, n);
      wait_pat(on_p, 1'b0, 450, n);
      chk_span("on time", n, 75, 80);
      chk_word("off pattern", {28'h0, off_p}, {28'h0, pat1()});
      wait_pat(off_p, 1'b0, 450, m);
      chk_span("off span", n + m, plain ? 395 : 296, plain ? 402 : 304);
      chk_word("next pattern", {28'h0, plain ? on_p : late_p}, {28'h0, pat1()});
   endtask

   task automatic t_reset();
      apb(1'b0, `SMI_REG_CTRL, 32'h0);
      chk_word("ctrl", 32'h1, rd);
      chk_pos(7'h10);
      apb(1'b0, `SMI_REG_DAC, 32'h0);
      chk_word("home dac", 32'h4747, {16'h0, rd[15:0]});
      apb(1'b0, 8'h0C, 32'h0);
      chk_word("unmapped err", 32'h1, {31'h0, err});
      chk_word("unmapped data", 32'h0, rd);
      $display("test reset done");
   endtask

   task automatic t_formats();
      int stride [8] = '{32, 16, 8, 4, 2, 1, 1, 1};
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, `SMI_REG_CTRL, 32'h3);
         fmt <= c[2:0];
         ctl_u.steps(1, 1'b1);
         chk_pos(7'(16 + stride[c]));
         ctl_u.steps(1, 1'b0);
         chk_pos(7'h10);
      end
      $display("test formats done");
   endtask

   task automatic t_wrap();
      apb(1'b1, `SMI_REG_CTRL, 32'h3);
      fmt <= 3'h0;
      ctl_u.steps(1, 1'b0);
      chk_pos(7'h70);
      ctl_u.steps(3, 1'b1);
      chk_pos(7'h50);
      home_n <= 1'b0;
      repeat (6) @(posedge pclk);
      home_n <= 1'b1;
      repeat (4) @(posedge pclk);
      chk_pos(7'h10);
      $display("test wrap done");
   endtask

   task automatic t_change();
      fmt <= 3'h5;
      ctl_u.steps(1, 1'b1);
      apb(1'b0, `SMI_REG_DAC, 32'h0);
      chk_word("dac 17", 32'h4A43, {16'h0, rd[15:0]});
      fmt <= 3'h0;
      ctl_u.steps(1, 1'b1);
      chk_pos(7'h30);
      fmt <= 3'h5;
      ctl_u.steps(1, 1'b1);
      fmt <= 3'h0;
      ctl_u.steps(1, 1'b0);
      chk_pos(7'h30);
      apb(1'b0, `SMI_REG_DAC, 32'h0);
      chk_word("dac 48", 32'h47C7, {16'h0, rd[15:0]});
      $display("test change done");
   endtask

   task automatic t_chop();
      int n;
      chop_period(4'h6, 4'h5, 4'h5);
      apb(1'b1, `SMI_REG_CTRL, 32'h3);
      fmt <= 3'h5;
      chop_period(4'h9, 4'h5, 4'h5);
      // 70 x 500 sits just under 500 x 71
      refv <= 10'h1F4;
      sense <= 10'h046;
      repeat (450) @(posedge pclk);
      wait_pat(4'h9, 1'b0, 400, n);
      chk_span("untripped", n, 400, 400);
      sense <= 10'h047;
      chop_period(4'h9, 4'h5, 4'h5);
      refv <= 10'h3E8;
      sense <= 10'h3FF;
      dec_lvl <= 1'b1;
      chop_period(4'h9, 4'h6, 4'h6);
      wait_pat(4'h6, 1'b1, 200, n);
      sense <= 10'h000;
      wait_pat(4'h0, 1'b1, 12, n);
      chk_span("zero stop", n, 1, 10);
      sense <= 10'h3FF;
      dec_open <= 1'b1;
      chop_period(4'h9, 4'h5, 4'h5);
      ctl_u.steps(1, 1'b1);
      chop_period(4'h9, 4'h6, 4'h5);
      $display("test chop done");
   endtask

   task automatic t_disable();
      en_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chk_word("bridges disabled", 32'h0, {24'h0, a_hi, a_lo, b_hi, b_lo});
      chk_pos(7'h11);
      chk_word("status flags", 32'h1, {27'h0, rd[15:11]});
      en_n <= 1'b0;
      wake_n <= 1'b0;
      // A whole period, so a missing sleep gate would drive again
      repeat (450) @(posedge pclk);
      chk_word("bridges asleep", 32'h0, {24'h0, a_hi, a_lo, b_hi, b_lo});
      wake_n <= 1'b1;
      apb(1'b1, `SMI_REG_CTRL, 32'h0);
      repeat (450) @(posedge pclk);
      chk_word("bridges ctrl off", 32'h0, {24'h0, a_hi, a_lo, b_hi, b_lo});
      apb(1'b0, `SMI_REG_CTRL, 32'h0);
      chk_word("ctrl cleared", 32'h0, rd);
      $display("test disable done");
   endtask

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_reset();
      t_formats();
      t_wrap();
      t_change();
      t_chop();
      t_disable();
      end_of_test();
   end

   initial
   begin
      repeat (80000) @(posedge pclk);
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule
